// File: hw/ipc_top.sv
// idle and power-down sequencer for the small 8-bit core
// assumes the core pulses instr_done at instruction end and accepts
// cpu_clk_en; interrupt controller supplies pending/enable/priority
// Functional notes
// [RULE1] idle starts after the setting instruction completes
// [RULE2] idle gates cpu clock, peripherals keep running
// [RULE3] all cpu state held through idle
// [RULE4] ports freeze at idle entry level
// [RULE5] address and program strobes high in idle
// [RULE6] enabled interrupt clears idle bit, gets serviced
// [RULE7] resume after idling instruction following return
// [RULE8] idle reset held at least 24 oscillator periods
// [RULE9] power-down stops oscillator after invoking instruction
// [RULE10] ram and registers kept during power-down
// [RULE11] only reset or ext irq pins exit
// [RULE12] low pin restarts oscillator, high completes exit
// [RULE13] both enabled: first release completes the exit
// [RULE14] higher priority pin routine gets serviced
// [RULE15] resume after power-down instruction following return
// [RULE16] reset exit reinitialises registers, interrupt exit not
// [RULE17] ram untouched by either exit path
// [RULE18] both bits set: power-down exit, both cleared
// [RULE19] waker holds signal until oscillator stable
// [RULE20] port 0 only drives zero when low power
// [RULE21] sleep bit one starts power-down, reset clears
// [RULE22] low-level detect works with oscillator stopped
`timescale 1ns/10ps
module ipc_top
   import ipc_pkg::*;
#(
   parameter int W         = IPC_PORT_W,
   parameter int START_CYC = IPC_OSC_START_CYC
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic         ctrl_wr,
   input  wire logic [7:0]   ctrl_wdata,
   input  wire logic         instr_done,
   input  wire logic         irq_pending,
   input  wire logic         irq_taken,
   input  wire logic         ext_irq_zero,
   input  wire logic         ext_irq_one,
   input  wire logic [1:0]   ext_irq_enable,
   input  wire logic [1:0]   ext_irq_zero_prio,
   input  wire logic [1:0]   ext_irq_one_prio,
   input  wire logic         addr_strobe_core,
   input  wire logic         program_store_strobe_core,
   input  wire logic [W-1:0] port0_core,
   input  wire logic [W-1:0] port1_core,
   input  wire logic [W-1:0] port2_core,
   input  wire logic [W-1:0] port3_core,
   output logic [7:0]        power_control_reg,
   output logic              cpu_clk_en,
   output logic              periph_clk_en,
   output logic              osc_run,
   output logic              wake_valid,
   output logic              wake_vector_one,
   output logic              addr_strobe,
   output logic              program_store_strobe,
   output logic [W-1:0]      port0_out,
   output logic [W-1:0]      port0_oe_n,
   output logic [W-1:0]      port1_out,
   output logic [W-1:0]      port2_out,
   output logic [W-1:0]      port3_out
);
   localparam int CW = $clog2(START_CYC + 1);

   ipc_state_type state;
   ipc_state_type next_state;
   logic [7:0]    ctrl;
   logic [7:0]    next_ctrl;
   logic [CW-1:0] start_cnt;
   logic [CW-1:0] next_start_cnt;
   logic          pend_idle;
   logic          pend_sleep;
   logic          next_pend_idle;
   logic          next_pend_sleep;
   logic          any_low;
   logic [1:0]    released;
   logic [1:0]    ext_pins;
   logic          low_power;
   logic          in_idle;
   logic          in_sleep;
   logic          pick_one;
   logic [W-1:0]  p0_h;
   logic [W-1:0]  p1_h;
   logic [W-1:0]  p2_h;
   logic [W-1:0]  p3_h;
   logic          freeze;
   // named decode for the sequencer and the output flops
   logic [1:0]    taking_part;
   logic          go_sleep;
   logic          go_idle;
   logic          cnt_busy;
   logic          wake_done;
   logic [W-1:0]  next_port0_oe_n;

   assign ext_pins = {ext_irq_one, ext_irq_zero};

   ipc_wake_detect #(
      .N(2)
   ) u_wake (
      .clk      (clk),
      .arst_n   (arst_n),
      .pin      (ext_pins),
      .enable   (ext_irq_enable),
      .any_low  (any_low),
      .released (released)
   );

   assign in_idle   = (state == IPC_IDLE);
   assign in_sleep  = (state == IPC_SLEEP) || (state == IPC_WAKE);
   assign low_power = in_idle || in_sleep;
   assign freeze    = low_power;

   // one snapshot per port; a loop over unlike-named ports would not help
   ipc_strobe_hold #(.W(W)) u_p0 (
      .clk(clk), .arst_n(arst_n), .freeze(freeze),
      .live(port0_core), .held(p0_h));
   ipc_strobe_hold #(.W(W)) u_p1 (
      .clk(clk), .arst_n(arst_n), .freeze(freeze),
      .live(port1_core), .held(p1_h));
   ipc_strobe_hold #(.W(W)) u_p2 (
      .clk(clk), .arst_n(arst_n), .freeze(freeze),
      .live(port2_core), .held(p2_h));
   ipc_strobe_hold #(.W(W)) u_p3 (
      .clk(clk), .arst_n(arst_n), .freeze(freeze),
      .live(port3_core), .held(p3_h));

   // a pin still held low at the release took part in the wake too, so
   // priority is weighed over every such pin, not the released one alone
   assign taking_part = released | (ext_irq_enable & ~ext_pins);
   // equal levels fall back to the polling order, pin zero first
   assign pick_one = (taking_part == 2'b10) ||
                     (taking_part == 2'b11 &&
                      ext_irq_one_prio > ext_irq_zero_prio); // [RULE14]

   // power-down wins when both requests stand
   assign go_sleep  = instr_done && pend_sleep; // [RULE18]
   assign go_idle   = instr_done && pend_idle && !pend_sleep;
   assign cnt_busy  = (start_cnt != '0);
   // a release during the restart count is lost; a later release after the count still completes the exit
   assign wake_done = !cnt_busy && |released;

   always_comb begin
      next_state      = state;
      next_ctrl       = ctrl;
      next_start_cnt  = start_cnt;
      next_pend_idle  = pend_idle;
      next_pend_sleep = pend_sleep;
      if (ctrl_wr) begin
         next_ctrl       = ctrl_wdata;
         next_pend_idle  = ctrl_wdata[IPC_IDLE_BIT];
         next_pend_sleep = ctrl_wdata[IPC_SLEEP_BIT]; // [RULE21]
      end
      case (state)
         IPC_RUN: begin
            // entry waits for the writing instruction to retire
            if (go_sleep) begin
               next_state      = IPC_SLEEP; // [RULE9] [RULE18]
               next_pend_sleep = 1'b0;
               next_pend_idle  = 1'b0;
            end else if (go_idle) begin
               next_state     = IPC_IDLE; // [RULE1]
               next_pend_idle = 1'b0;
            end
         end
         IPC_IDLE: begin
            if (irq_pending) begin
               next_ctrl[IPC_IDLE_BIT] = 1'b0; // [RULE6]
               next_state              = IPC_EXIT;
            end
         end
         IPC_SLEEP: begin
            // only the pin detector can restart the oscillator
            if (any_low) begin
               next_state     = IPC_WAKE; // [RULE11] [RULE12] [RULE13]
               next_start_cnt = CW'(START_CYC);
            end
         end
         IPC_WAKE: begin
            if (cnt_busy)
               next_start_cnt = start_cnt - CW'(1);
            // a release before stable start is ignored; waker must hold
            if (wake_done) begin
               next_ctrl[IPC_IDLE_BIT]  = 1'b0; // [RULE18] [RULE19]
               next_ctrl[IPC_SLEEP_BIT] = 1'b0;
               next_state               = IPC_EXIT; // [RULE13]
            end
         end
         IPC_EXIT: begin
            // core resumes with pc untouched, so the return lands after
            // the entering instruction
            if (irq_taken) next_state = IPC_RUN; // [RULE7] [RULE15]
         end
         default: next_state = IPC_RUN;
      endcase
   end

   // reset reinitialises control; ram and core state live elsewhere and
   // are never touched here
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state      <= IPC_RUN;
         ctrl       <= IPC_CTRL_RESET; // [RULE16] [RULE21] [RULE8]
         start_cnt  <= '0;
         pend_idle  <= 1'b0;
         pend_sleep <= 1'b0;
      end else begin
         state      <= next_state;
         ctrl       <= next_ctrl; // [RULE10] [RULE17]
         start_cnt  <= next_start_cnt;
         pend_idle  <= next_pend_idle;
         pend_sleep <= next_pend_sleep;
      end
   end

   logic          wake_pulse;
   logic          next_idle;
   logic          next_asleep;
   logic          next_cpu_clk_en;
   logic          next_periph_clk_en;
   logic          next_osc_run;
   logic          next_addr_strobe;
   logic          next_program_store_strobe;
   logic          next_wake_vector_one;

   assign wake_pulse  = (state == IPC_WAKE) && (next_state == IPC_EXIT);
   assign next_idle   = (next_state == IPC_IDLE);
   assign next_asleep = (next_state == IPC_SLEEP) ||
                        (next_state == IPC_WAKE);

   // decoded from next_state so every clock and strobe pin flips on the entry edge itself; port0_oe_n follows state, one edge later
   // core clock gated keeps every cpu register frozen
   assign next_cpu_clk_en    = (next_state == IPC_RUN) ||
                               (next_state == IPC_EXIT); // [RULE2] [RULE3]
   assign next_periph_clk_en = !next_asleep; // [RULE2]
   assign next_osc_run       = (next_state != IPC_SLEEP); // [RULE9] [RULE12]
   // strobes high in idle, low in power-down, the core's own in run
   assign next_addr_strobe   = next_idle   ? 1'b1 : // [RULE5]
                               next_asleep ? 1'b0 : addr_strobe_core;
   assign next_program_store_strobe = next_idle   ? 1'b1 : // [RULE5]
                                      next_asleep ? 1'b0 :
                                      program_store_strobe_core;
   // the vector choice stands until the next wake
   assign next_wake_vector_one = wake_pulse ? pick_one :
                                 wake_vector_one; // [RULE14]
   // a held one floats in low power; a zero is actively driven
   assign next_port0_oe_n = low_power ? p0_h : '0; // [RULE20]

   // output flops only; the decode stays in the assigns above
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         power_control_reg    <= IPC_CTRL_RESET;
         cpu_clk_en           <= 1'b1;
         periph_clk_en        <= 1'b1;
         osc_run              <= 1'b1;
         wake_valid           <= 1'b0;
         wake_vector_one      <= 1'b0;
         addr_strobe          <= 1'b1;
         program_store_strobe <= 1'b1;
      end else begin
         power_control_reg    <= next_ctrl;
         cpu_clk_en           <= next_cpu_clk_en;
         periph_clk_en        <= next_periph_clk_en;
         osc_run              <= next_osc_run;
         wake_valid           <= wake_pulse;
         wake_vector_one      <= next_wake_vector_one;
         addr_strobe          <= next_addr_strobe;
         program_store_strobe <= next_program_store_strobe;
      end
   end

   genvar b;
   generate
      for (b = 0; b < W; b++) begin : g_p0
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
               port0_out[b]  <= 1'b0;
               port0_oe_n[b] <= 1'b1;
            end else begin
               port0_out[b]  <= 1'b0;
               port0_oe_n[b] <= next_port0_oe_n[b]; // [RULE20]
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         port1_out <= '1;
         port2_out <= '1;
         port3_out <= '1;
      end else begin
         port1_out <= p1_h; // [RULE4]
         port2_out <= p2_h;
         port3_out <= p3_h;
      end
   end
endmodule

// File: hw/ipc_pkg.sv
// power-mode control constants: control bit layout, reset values, timing
// assumes one core clock at 250 MHz; used by all ipc modules
package ipc_pkg;
   localparam int          IPC_IDLE_BIT      = 0;
   localparam int          IPC_SLEEP_BIT     = 1;
   localparam int          IPC_CTRL_W        = 8;
   localparam logic [7:0]  IPC_CTRL_RESET    = 8'h10;
   localparam int          IPC_PORT_W        = 8;
   localparam int          IPC_OSC_PER_MC    = 12;
   localparam int          IPC_RESET_MC      = 2;
   localparam int          IPC_RESET_OSC     = IPC_OSC_PER_MC * IPC_RESET_MC;
   localparam real         IPC_CLK_NS        = 4.0;
   localparam real         IPC_OSC_START_NS  = 400.0;
   localparam int          IPC_OSC_START_CYC =
      (IPC_OSC_START_NS / IPC_CLK_NS) < 1.0 ? 1 :
      int'($ceil(IPC_OSC_START_NS / IPC_CLK_NS));
   localparam logic [1:0]  IPC_PRIO_LOWEST   = 2'h0;
   typedef enum logic [2:0] {
      IPC_RUN,
      IPC_IDLE,
      IPC_SLEEP,
      IPC_WAKE,
      IPC_EXIT
   } ipc_state_type;
endpackage

// File: hw/ipc_wake_detect.sv
// low-level wake detector for the two external interrupt pins
// assumes pins are synchronous to clk; level path is combinational so it
// still sees a low pin while the oscillator is stopped
`timescale 1ns/10ps
module ipc_wake_detect
   import ipc_pkg::*;
#(
   parameter int N = 2
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic [N-1:0] pin,
   input  wire logic [N-1:0] enable,
   output logic              any_low,
   output logic [N-1:0]      released
);
   logic [N-1:0] was_low;
   logic [N-1:0] low_now;
   assign low_now = enable & ~pin;
   // oscillator-free path to the restart request
   assign any_low = |low_now; // [RULE22]
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_pin
         always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) was_low[g] <= 1'b0;
            else         was_low[g] <= low_now[g];
         end
         assign released[g] = was_low[g] & pin[g] & enable[g]; // [RULE12]
      end
   endgenerate
endmodule

// File: hw/ipc_strobe_hold.sv
// per-mode port pin freeze: snapshots ports on mode entry
// assumes freeze is a level from the sequencer
`timescale 1ns/10ps
module ipc_strobe_hold
   import ipc_pkg::*;
#(
   parameter int W = IPC_PORT_W
) (
   input  wire logic         clk,
   input  wire logic         arst_n,
   input  wire logic         freeze,
   input  wire logic [W-1:0] live,
   output logic [W-1:0]      held
);
   logic         frozen_q;
   logic [W-1:0] snap;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) frozen_q <= 1'b0;
      else         frozen_q <= freeze;
   end
   // capture only on the entry edge so later core writes cannot leak out
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n)                  snap <= '0;
      else if (freeze && !frozen_q) snap <= live; // [RULE4]
   end
   assign held = (freeze && frozen_q) ? snap : live;
endmodule

// File: verif/ipc_top_properties.sv
// checker for the idle and power-down sequencer's mode outputs
// assumes it is bound into ipc_top; single clock domain
`timescale 1ns/10ps
module ipc_chk
   import ipc_pkg::*;
#(
   parameter int W = IPC_PORT_W
) (
   input wire logic         clk,
   input wire logic         arst_n,
   input wire logic         instr_done,
   input wire logic         irq_pending,
   input wire logic         ext_irq_zero,
   input wire logic         ext_irq_one,
   input wire logic [1:0]   ext_irq_enable,
   input wire logic [7:0]   power_control_reg,
   input wire logic         cpu_clk_en,
   input wire logic         periph_clk_en,
   input wire logic         osc_run,
   input wire logic         wake_valid,
   input wire logic         addr_strobe,
   input wire logic         program_store_strobe,
   input wire logic [W-1:0] port0_oe_n,
   input wire logic [W-1:0] port1_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire idle_now = !cpu_clk_en && periph_clk_en;
   wire pin_low  = (!ext_irq_zero && ext_irq_enable[0]) ||
                   (!ext_irq_one && ext_irq_enable[1]);
   sequence s_idle_go;
      cpu_clk_en && instr_done && power_control_reg[1:0] == 2'h1;
   endsequence
   sequence s_sleep_go;
      cpu_clk_en && instr_done && power_control_reg[1];
   endsequence
   sequence s_asleep_woken;
      !osc_run && pin_low;
   endsequence
   a_idle_entry: assert property (s_idle_go |=> idle_now)
      else $error("idle not entered after retire");
   a_idle_strobes: assert property (
      idle_now |-> addr_strobe && program_store_strobe)
      else $error("strobes not high in idle");
   a_idle_ports: assert property (
      idle_now [*3] |-> $stable(port1_out) && $stable(port0_oe_n))
      else $error("ports moved in idle");
   a_idle_wake: assert property (
      idle_now && irq_pending |=> cpu_clk_en && !power_control_reg[0])
      else $error("idle not ended by interrupt");
   a_sleep_entry: assert property (s_sleep_go |=>
      !osc_run && !periph_clk_en && !addr_strobe && !program_store_strobe)
      else $error("power-down entry wrong");
   a_sleep_hold: assert property (
      !osc_run [*2] |-> $stable(port1_out) && $stable(power_control_reg))
      else $error("state changed in power-down");
   a_pin_restart: assert property (
      s_asleep_woken |-> ##[1:2] osc_run)
      else $error("oscillator not restarted");
   a_masked_sleep: assert property (
      !osc_run && !pin_low |=> !osc_run)
      else $error("woke without enabled pin");
   a_wake_pulse: assert property (wake_valid |=> !wake_valid)
      else $error("wake pulse too long");
   a_wake_clears: assert property (
      wake_valid |-> ##[0:1] power_control_reg[1:0] == 2'h0)
      else $error("mode bits not cleared");
   a_restart_wait: assert property (
      $rose(osc_run) |-> !wake_valid [*2])
      else $error("exit before restart count");
endmodule

bind ipc_top ipc_chk #(.W(W)) i_ipc_chk (
   .clk, .arst_n, .instr_done, .irq_pending, .ext_irq_zero, .ext_irq_one,
   .ext_irq_enable, .power_control_reg, .cpu_clk_en, .periph_clk_en,
   .osc_run, .wake_valid, .addr_strobe, .program_store_strobe,
   .port0_oe_n, .port1_out
);

// File: verif/ipc_core_model.sv
// core-side partner: writes the control byte, retires the instruction
// and vectors to the wake routine after a settable latency
// assumes a bench that drives on the falling edge of the shared clk
`timescale 1ns/10ps
module ipc_core_model
   import ipc_pkg::*;
(
   input  wire logic  clk,
   input  wire logic  arst_n,
   input  wire logic  cpu_clk_en,
   input  wire logic  wake_valid,
   output logic       ctrl_wr,
   output logic [7:0] ctrl_wdata,
   output logic       instr_done,
   output logic       irq_taken
);
   int lat = 1;
   initial begin
      ctrl_wr = 1'b0;
      ctrl_wdata = 8'h00;
      instr_done = 1'b0;
      irq_taken = 1'b0;
   end
   task automatic enter(input logic [7:0] v);
      @(negedge clk);
      ctrl_wr = 1'b1;
      ctrl_wdata = v;
      @(negedge clk);
      ctrl_wr = 1'b0;
      instr_done = 1'b1;
      @(negedge clk);
      instr_done = 1'b0;
   endtask
   // a slow vector keeps the exit state standing longer
   always @(posedge cpu_clk_en or posedge wake_valid) begin
      if (arst_n === 1'b1) begin
         repeat (lat) @(negedge clk);
         irq_taken = 1'b1;
         @(negedge clk);
         irq_taken = 1'b0;
      end
   end
endmodule

// File: verif/idle_powerdown_control_tb.sv
// bench for the idle and power-down sequencer with a core-side model
// assumes pins driven on the falling edge; restart count shortened to 2
`timescale 1ns/10ps
module idle_powerdown_control_tb;
   import ipc_pkg::*;
   localparam int SC = 2;
   logic       clk = 1'b0, arst_n = 1'b0, irq_pending = 1'b0;
   logic       ext_irq_zero = 1'b1, ext_irq_one = 1'b1;
   logic [1:0] ext_irq_enable = 2'h0, ext_irq_zero_prio = 2'h0;
   logic [1:0] ext_irq_one_prio = 2'h0;
   logic [7:0] p0 = 8'h5a, p1 = 8'h3c, p2 = 8'h96;
   logic       strb = 1'b0;
   logic       ctrl_wr, instr_done, irq_taken, cpu_clk_en, periph_clk_en;
   logic       osc_run, wake_valid, wake_vector_one, addr_strobe;
   logic       program_store_strobe;
   logic [7:0] ctrl_wdata, power_control_reg, port0_out, port0_oe_n;
   logic [7:0] port1_out, port2_out, port3_out;
   int         err_count = 0, cmp_count = 0, cyc = 0;
   always #2 clk = ~clk;
   ipc_core_model i_ipc_core_model (.clk, .arst_n, .cpu_clk_en,
      .wake_valid, .ctrl_wr, .ctrl_wdata, .instr_done, .irq_taken);
   ipc_top #(.START_CYC(SC)) i_ipc_top (.clk, .arst_n, .ctrl_wr,
      .ctrl_wdata, .instr_done, .irq_pending, .irq_taken, .ext_irq_zero,
      .ext_irq_one, .ext_irq_enable, .ext_irq_zero_prio, .ext_irq_one_prio,
      .addr_strobe_core(strb), .program_store_strobe_core(strb),
      .port0_core(p0), .port1_core(p1), .port2_core(p2),
      .port3_core(8'h00), .power_control_reg, .cpu_clk_en, .periph_clk_en,
      .osc_run, .wake_valid, .wake_vector_one, .addr_strobe,
      .program_store_strobe, .port0_out, .port0_oe_n, .port1_out,
      .port2_out, .port3_out);
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      cmp_count++;
      if (g !== e) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk1(input logic g, input logic e);
      chk({7'h0, g}, {7'h0, e});
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic go(input logic [7:0] v);
      i_ipc_core_model.enter(v);
      tick(2);
   endtask
   task automatic wait_wake();
      for (int i = 0; i < 50 && wake_valid !== 1'b1; i++) tick(1);
      chk1(wake_valid, 1'b1);
   endtask
   task automatic t_reset_exit(input logic [7:0] v);
      go(v);
      arst_n = 1'b0;
      tick(24);
      chk(power_control_reg, 8'h10);
      arst_n = 1'b1;
      tick(2);
      chk1(cpu_clk_en & osc_run, 1'b1);
   endtask
   task automatic t_idle();
      go(8'h11);
      chk1(cpu_clk_en, 1'b0);
      chk1(periph_clk_en & osc_run, 1'b1);
      chk1(addr_strobe & program_store_strobe, 1'b1);
      p1 = 8'hc3;
      tick(2);
      chk(port1_out, 8'h3c);
      chk(port0_oe_n, 8'h5a);
      chk(port0_out, 8'h00);
      chk(port3_out, 8'h00);
      irq_pending = 1'b1;
      tick(2);
      irq_pending = 1'b0;
      chk1(cpu_clk_en, 1'b1);
      chk1(power_control_reg[0], 1'b0);
      tick(8);
      chk(port1_out, 8'hc3);
   endtask
   task automatic t_sleep_zero();
      ext_irq_enable = 2'h1;
      strb = 1'b1;
      go(8'h32);
      chk1(osc_run | periph_clk_en | addr_strobe, 1'b0);
      chk1(program_store_strobe, 1'b0);
      p2 = 8'h00;
      ext_irq_zero = 1'b0;
      tick(SC + 8); // pin held past the restart
      chk1(osc_run, 1'b1);
      chk(port2_out, 8'h96);
      ext_irq_zero = 1'b1;
      wait_wake();
      chk1(wake_vector_one, 1'b0);
      tick(1);
      chk(power_control_reg, 8'h30);
      p2 = 8'h96;
      tick(8);
      chk1(cpu_clk_en, 1'b1);
      chk1(addr_strobe & program_store_strobe, 1'b1);
   endtask
   task automatic t_sleep_both();
      ext_irq_enable = 2'h2;
      i_ipc_core_model.lat = 6;
      go(8'h13);
      ext_irq_zero = 1'b0;
      irq_pending = 1'b1;
      tick(6);
      chk1(osc_run, 1'b0);
      irq_pending = 1'b0;
      ext_irq_enable = 2'h3;
      ext_irq_zero_prio = 2'h1;
      ext_irq_one_prio = 2'h2;
      ext_irq_one = 1'b0;
      tick(SC + 8);
      ext_irq_zero = 1'b1;
      wait_wake();
      chk1(wake_vector_one, 1'b1);
      ext_irq_one = 1'b1;
      tick(1);
      chk(power_control_reg, 8'h10);
      tick(10);
      chk1(cpu_clk_en & periph_clk_en, 1'b1);
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 4000) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      tick(5);
      chk(power_control_reg, 8'h10);
      chk(port0_oe_n, 8'hff);
      arst_n = 1'b1;
      tick(2);
      t_idle();
      t_reset_exit(8'h01);
      t_sleep_zero();
      t_sleep_both();
      t_reset_exit(8'h02);
      final_report();
   end
endmodule
